// File: sfpi_pkg.sv
`default_nettype none
package sfpi_pkg;
  // ****************************************
  // Array geometry
  // ****************************************
  localparam int PAGE_BYTES  = 256;
  localparam int PAGE_COUNT  = 65536;
  localparam int ARRAY_BYTES = PAGE_COUNT * PAGE_BYTES;
  localparam int ADDR_W      = 24;
  localparam int SEC_BYTES   = 4096;
  localparam int BLK32_BYTES = 32768;
  localparam int BLK64_BYTES = 65536;
  localparam int DUMMY_CLKS  = 8;

  // ****************************************
  // Command codes
  // ****************************************
  localparam logic [7:0] OPC_READ      = 8'h03;
  localparam logic [7:0] OPC_DUAL_READ = 8'h3b;
  localparam logic [7:0] OPC_QUAD_READ = 8'h6b;
  localparam logic [7:0] OPC_PAGE_PROG = 8'h02;
  localparam logic [7:0] OPC_ERASE_4K  = 8'h20;
  localparam logic [7:0] OPC_ERASE_32K = 8'h52;
  localparam logic [7:0] OPC_ERASE_64K = 8'hd8;
  localparam logic [7:0] OPC_CHIP_ERA  = 8'hc7;
  localparam logic [7:0] OPC_WR_STATUS = 8'h01;

  typedef enum logic [2:0] {
    CL_NONE, CL_READ, CL_PROG, CL_ERASE, CL_CHIP, CL_WSTAT
  } sfpi_class_t;
  typedef enum logic [1:0] {KD_OPC, KD_ADDR, KD_DATA} sfpi_kind_t;
  typedef enum logic [1:0] {EU_4K, EU_32K, EU_64K, EU_CHIP} sfpi_unit_t;
  typedef enum logic [1:0] {LN_1, LN_2, LN_4} sfpi_lanes_t;

  function automatic sfpi_class_t op_class(input logic [7:0] op,
                                           input logic       qe);
    case (op)
      OPC_READ, OPC_DUAL_READ:   return CL_READ;
      OPC_QUAD_READ:             return qe ? CL_READ : CL_NONE;
      OPC_PAGE_PROG:             return CL_PROG;
      OPC_ERASE_4K, OPC_ERASE_32K,
      OPC_ERASE_64K:             return CL_ERASE;
      OPC_CHIP_ERA:              return CL_CHIP;
      OPC_WR_STATUS:             return CL_WSTAT;
      default:                   return CL_NONE;
    endcase
  endfunction

  function automatic sfpi_lanes_t op_lanes(input logic [7:0] op);
    case (op)
      OPC_DUAL_READ: return LN_2;
      OPC_QUAD_READ: return LN_4;
      default:       return LN_1;
    endcase
  endfunction

  function automatic sfpi_unit_t op_unit(input logic [7:0] op);
    case (op)
      OPC_ERASE_4K:  return EU_4K;
      OPC_ERASE_32K: return EU_32K;
      OPC_ERASE_64K: return EU_64K;
      default:       return EU_CHIP;
    endcase
  endfunction
endpackage
`default_nettype wire

// File: sfpi_stream_if.sv
`default_nettype none
interface sfpi_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: sfpi_buf2.sv
`default_nettype none
module sfpi_buf2 #(
  parameter int W     = 8,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  // Streams
  sfpi_stream_if.snk wr,
  sfpi_stream_if.src rd
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [W-1:0]  mem_q [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  logic          push;
  logic          pop;

  function automatic logic [AW-1:0] nxt(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction

  assign wr.ready = (cnt_q != (AW + 1)'(DEPTH));
  assign rd.valid = (cnt_q != '0);
  assign rd.data  = mem_q[rp_q];
  assign push     = wr.valid & wr.ready;
  assign pop      = rd.valid & rd.ready;

  always_ff @(posedge clk) begin
    if (ce && push) begin
      mem_q[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else if (ce) begin
      if (push) begin
        wp_q <= nxt(wp_q);
      end
      if (pop) begin
        rp_q <= nxt(rp_q);
      end
      cnt_q <= cnt_q + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule
`default_nettype wire

// File: sfpi_top.sv
`default_nettype none
module sfpi_top #(
  parameter int DUMMY_CLKS = sfpi_pkg::DUMMY_CLKS
) (
  // System clock and reset
  input  wire logic        CLK_SYS,
  input  wire logic        NRST,
  input  wire logic        CE,
  // Flash pins
  input  wire logic        CS_N,
  input  wire logic        SCK,
  input  wire logic [3:0]  IO_IN,
  output logic      [3:0]  IO_OUT,
  output logic      [3:0]  IO_OE,
  // Status register bits
  input  wire logic        QUAD_LANES_ENABLE,
  input  wire logic [1:0]  STATUS_LOCK_BITS,
  input  wire logic        SECTOR_GRANULARITY_SELECT,
  input  wire logic        TOP_BOTTOM_SELECT,
  input  wire logic        BLOCK_PROTECT_LEVEL_2,
  input  wire logic        BLOCK_PROTECT_LEVEL_1,
  input  wire logic        BLOCK_PROTECT_LEVEL_0,
  input  wire logic        BUSY,
  // Read data stream
  input  wire logic [7:0]  TX_DATA,
  input  wire logic        TX_VALID,
  output logic             TX_READY,
  // Decoded requests
  output logic [23:0]      CMD_ADDR,
  output logic             READ_START,
  output logic             ERASE_VALID,
  output logic [1:0]       ERASE_UNIT,
  output logic             PROG_VALID,
  output logic [7:0]       PROG_DATA,
  output logic             STATUS_WR_VALID,
  output logic [7:0]       STATUS_WR_DATA,
  output logic             CMD_REJECTED,
  output logic             TX_UNDERRUN,
  // Power and protection state
  output logic             STANDBY,
  output logic             ACTIVE,
  output logic             POWERUP_EDGE_SEEN,
  output logic             HW_GUARD_ACTIVE
);
  typedef enum logic [2:0] {
    PH_OPC, PH_ADDR, PH_DUMMY, PH_DIN, PH_DOUT, PH_IDLE
  } sfpi_phase_t;

  // ****************************************
  // Link side declarations
  // ****************************************
  sfpi_phase_t          ph_q;
  sfpi_pkg::sfpi_lanes_t lanes_q;
  sfpi_pkg::sfpi_class_t cls_l_q;
  sfpi_pkg::sfpi_kind_t  rx_kind_q;
  logic [4:0]           cnt_q;
  logic [7:0]           sh_q;
  logic [7:0]           sh_nx;
  logic                 qe_l1_q;
  logic                 qe_l2_q;
  logic [7:0]           rx_byte_q;
  logic                 rx_tog_q;
  logic                 byte_done;
  logic [7:0]           out_sh_q;
  logic [7:0]           byte_src;
  logic [2:0]           ocnt_q;
  logic                 txr_tog_q;
  logic [3:0]           io_out_q;
  logic [3:0]           io_oe_q;

  // ****************************************
  // System side declarations
  // ****************************************
  sfpi_pkg::sfpi_class_t cls_q;
  logic       cs_s1_q, cs_s2_q, cs_s3_q;
  logic       wp_s1_q, wp_s2_q;
  logic       rxt_s1_q, rxt_s2_q, rxt_s3_q;
  logic       txr_s1_q, txr_s2_q, txr_s3_q;
  logic       rx_seen_q, tx_seen_q;
  logic       rx_ev, tx_ev, fill;
  logic       armed_q, frame_ok_q;
  logic [7:0] opc_q;
  logic [15:0] addr_q;
  logic [1:0] abytes_q;
  logic [23:0] base_q;
  logic [8:0] pcnt_q;
  logic [7:0] tx_word_q;
  logic       tx_valid_q;
  logic [2:0] bp;
  logic       guard;
  logic       st_locked;
  logic [23:0] full_addr;
  logic [23:0] era_addr;
  logic [23:0] prog_addr;

  sfpi_stream_if #(.W(8)) tx_in_if ();
  sfpi_stream_if #(.W(8)) tx_out_if ();

  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic prot_hit(input logic [23:0] a,
                                    input logic [2:0]  lvl,
                                    input logic        tb,
                                    input logic        sec);
    logic [24:0] size;
    logic        hit;
    size = '0;
    hit  = 1'b0;
    if (lvl == 3'h7) begin
      hit = 1'b1;
    end else if (lvl != 3'h0) begin
      // Sector granularity saturates at the 32K size
      if (sec) begin
        size = 25'(sfpi_pkg::SEC_BYTES) << ((lvl > 3'h3) ? 3'h3
                                                          : lvl - 3'h1);
      end else begin
        size = 25'(sfpi_pkg::BLK64_BYTES) << (lvl - 3'h1);
      end
      if (tb) begin
        hit = ({1'b0, a} < size);
      end else begin
        hit = ({1'b0, a} >= (25'(sfpi_pkg::ARRAY_BYTES) - size));
      end
    end
    return hit;
  endfunction

  function automatic logic [23:0] unit_mask(input sfpi_pkg::sfpi_unit_t u);
    case (u)
      sfpi_pkg::EU_4K:  return 24'(sfpi_pkg::SEC_BYTES - 1);
      sfpi_pkg::EU_32K: return 24'(sfpi_pkg::BLK32_BYTES - 1);
      sfpi_pkg::EU_64K: return 24'(sfpi_pkg::BLK64_BYTES - 1);
      default:          return 24'(sfpi_pkg::ARRAY_BYTES - 1);
    endcase
  endfunction

  function automatic logic [3:0] lane_bits(input logic [7:0] b,
                                           input sfpi_pkg::sfpi_lanes_t l);
    case (l)
      sfpi_pkg::LN_2: return {2'h0, b[7:6]};
      sfpi_pkg::LN_4: return b[7:4];
      default:        return {2'h0, b[7], 1'b0};
    endcase
  endfunction

  function automatic logic [3:0] lane_oe(input sfpi_pkg::sfpi_lanes_t l);
    case (l)
      sfpi_pkg::LN_2: return 4'h3;
      sfpi_pkg::LN_4: return 4'hf;
      default:        return 4'h2;
    endcase
  endfunction

  function automatic logic [2:0] lane_last(input sfpi_pkg::sfpi_lanes_t l);
    case (l)
      sfpi_pkg::LN_2: return 3'h3;
      sfpi_pkg::LN_4: return 3'h1;
      default:        return 3'h7;
    endcase
  endfunction

  function automatic logic [7:0] lane_shift(input logic [7:0] b,
                                            input sfpi_pkg::sfpi_lanes_t l);
    case (l)
      sfpi_pkg::LN_2: return {b[5:0], 2'h0};
      sfpi_pkg::LN_4: return {b[3:0], 4'h0};
      default:        return {b[6:0], 1'b0};
    endcase
  endfunction

  // ****************************************
  // Link domain, rising edge
  // ****************************************
  assign sh_nx = {sh_q[6:0], IO_IN[0]};

  // Chip select high holds all link state in reset
  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      ph_q    <= PH_OPC;
      cnt_q   <= '0;
      sh_q    <= '0;
      lanes_q <= sfpi_pkg::LN_1;
      cls_l_q <= sfpi_pkg::CL_NONE;
      qe_l1_q <= 1'b0;
      qe_l2_q <= 1'b0;
    end else begin
      qe_l1_q <= QUAD_LANES_ENABLE;
      qe_l2_q <= qe_l1_q;
      sh_q    <= sh_nx;
      cnt_q   <= cnt_q + 5'h01;
      case (ph_q)
        PH_OPC: begin
          if (cnt_q == 5'h07) begin
            cnt_q   <= '0;
            cls_l_q <= sfpi_pkg::op_class(sh_nx, qe_l2_q);
            lanes_q <= sfpi_pkg::op_lanes(sh_nx);
            case (sfpi_pkg::op_class(sh_nx, qe_l2_q))
              sfpi_pkg::CL_READ,
              sfpi_pkg::CL_PROG,
              sfpi_pkg::CL_ERASE: ph_q <= PH_ADDR;
              sfpi_pkg::CL_WSTAT: ph_q <= PH_DIN;
              default:            ph_q <= PH_IDLE;
            endcase
          end
        end
        PH_ADDR: begin
          if (cnt_q == 5'h17) begin
            cnt_q <= '0;
            case (cls_l_q)
              sfpi_pkg::CL_READ: begin
                ph_q <= (lanes_q == sfpi_pkg::LN_1) ? PH_DOUT : PH_DUMMY;
              end
              sfpi_pkg::CL_PROG: ph_q <= PH_DIN;
              default:           ph_q <= PH_IDLE;
            endcase
          end
        end
        PH_DUMMY: begin
          if (cnt_q == 5'(DUMMY_CLKS - 1)) begin
            ph_q <= PH_DOUT;
          end
        end
        default: begin
          ph_q <= ph_q;
        end
      endcase
    end
  end

  // Byte hand-off: word held stable for eight clocks after each toggle
  assign byte_done = (ph_q == PH_OPC || ph_q == PH_ADDR || ph_q == PH_DIN)
                     && (cnt_q[2:0] == 3'h7);

  always_ff @(posedge SCK or posedge CS_N) begin
    if (CS_N) begin
      rx_tog_q  <= 1'b0;
      rx_byte_q <= '0;
      rx_kind_q <= sfpi_pkg::KD_OPC;
    end else if (byte_done) begin
      rx_byte_q <= sh_nx;
      rx_tog_q  <= ~rx_tog_q;
      case (ph_q)
        PH_OPC:  rx_kind_q <= sfpi_pkg::KD_OPC;
        PH_ADDR: rx_kind_q <= sfpi_pkg::KD_ADDR;
        default: rx_kind_q <= sfpi_pkg::KD_DATA;
      endcase
    end
  end

  // ****************************************
  // Link domain, falling edge
  // ****************************************
  assign byte_src = (ocnt_q == 3'h0) ? tx_word_q : out_sh_q;

  // Falling edges outside the data phase (mode 3 idle) leave lanes alone
  always_ff @(negedge SCK or posedge CS_N) begin
    if (CS_N) begin
      out_sh_q  <= '0;
      ocnt_q    <= '0;
      txr_tog_q <= 1'b0;
      io_out_q  <= '0;
      io_oe_q   <= '0;
    end else if (ph_q == PH_DOUT) begin
      io_oe_q  <= lane_oe(lanes_q);
      io_out_q <= lane_bits(byte_src, lanes_q);
      out_sh_q <= lane_shift(byte_src, lanes_q);
      ocnt_q   <= (ocnt_q == lane_last(lanes_q)) ? 3'h0 : ocnt_q + 3'h1;
      if (ocnt_q == 3'h0) begin
        txr_tog_q <= ~txr_tog_q;
      end
    end
  end

  assign IO_OUT = io_out_q;
  assign IO_OE  = io_oe_q;

  // ****************************************
  // System domain synchronisers
  // ****************************************
  // Toggles run three deep so a frame end is seen before their reset
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      cs_s1_q  <= 1'b0;
      cs_s2_q  <= 1'b0;
      cs_s3_q  <= 1'b0;
      wp_s1_q  <= 1'b1;
      wp_s2_q  <= 1'b1;
      rxt_s1_q <= 1'b0;
      rxt_s2_q <= 1'b0;
      rxt_s3_q <= 1'b0;
      txr_s1_q <= 1'b0;
      txr_s2_q <= 1'b0;
      txr_s3_q <= 1'b0;
    end else if (CE) begin
      cs_s1_q  <= CS_N;
      cs_s2_q  <= cs_s1_q;
      cs_s3_q  <= cs_s2_q;
      wp_s1_q  <= IO_IN[2];
      wp_s2_q  <= wp_s1_q;
      rxt_s1_q <= rx_tog_q;
      rxt_s2_q <= rxt_s1_q;
      rxt_s3_q <= rxt_s2_q;
      txr_s1_q <= txr_tog_q;
      txr_s2_q <= txr_s1_q;
      txr_s3_q <= txr_s2_q;
    end
  end

  assign rx_ev = (rxt_s3_q != rx_seen_q) && !cs_s2_q;
  assign tx_ev = (txr_s3_q != tx_seen_q) && !cs_s2_q;

  // ****************************************
  // Frame tracking and power state
  // ****************************************
  // Chip select stands low at reset release: no edge, frame not taken
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      armed_q    <= 1'b0;
      frame_ok_q <= 1'b0;
      rx_seen_q  <= 1'b0;
      tx_seen_q  <= 1'b0;
      STANDBY    <= 1'b0;
      ACTIVE     <= 1'b0;
    end else if (CE) begin
      if (cs_s2_q == 1'b0 && cs_s3_q == 1'b1) begin
        armed_q    <= 1'b1;
        frame_ok_q <= 1'b1;
      end else if (cs_s2_q) begin
        frame_ok_q <= 1'b0;
      end
      rx_seen_q <= cs_s2_q ? 1'b0 : rxt_s3_q;
      tx_seen_q <= cs_s2_q ? 1'b0 : txr_s3_q;
      STANDBY   <= cs_s2_q && !BUSY;
      ACTIVE    <= !cs_s2_q;
    end
  end

  assign POWERUP_EDGE_SEEN = armed_q;

  // ****************************************
  // Protection
  // ****************************************
  assign bp = {BLOCK_PROTECT_LEVEL_2, BLOCK_PROTECT_LEVEL_1,
               BLOCK_PROTECT_LEVEL_0};
  // Quad mode takes the guard pin as a data lane
  assign guard     = !QUAD_LANES_ENABLE && !wp_s2_q;
  assign st_locked = STATUS_LOCK_BITS[1]
                     || (STATUS_LOCK_BITS[0] && guard);
  assign full_addr = {addr_q, rx_byte_q};
  assign era_addr  = full_addr & ~unit_mask(sfpi_pkg::op_unit(opc_q));
  assign prog_addr = {base_q[23:8], base_q[7:0] + pcnt_q[7:0]};
  assign HW_GUARD_ACTIVE = guard;

  // ****************************************
  // Command decode
  // ****************************************
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      opc_q           <= '0;
      cls_q           <= sfpi_pkg::CL_NONE;
      addr_q          <= '0;
      abytes_q        <= '0;
      base_q          <= '0;
      pcnt_q          <= '0;
      CMD_ADDR        <= '0;
      READ_START      <= 1'b0;
      ERASE_VALID     <= 1'b0;
      ERASE_UNIT      <= '0;
      PROG_VALID      <= 1'b0;
      PROG_DATA       <= '0;
      STATUS_WR_VALID <= 1'b0;
      STATUS_WR_DATA  <= '0;
      CMD_REJECTED    <= 1'b0;
    end else if (CE) begin
      READ_START      <= 1'b0;
      ERASE_VALID     <= 1'b0;
      PROG_VALID      <= 1'b0;
      STATUS_WR_VALID <= 1'b0;
      CMD_REJECTED    <= 1'b0;
      if (rx_ev && frame_ok_q) begin
        case (rx_kind_q)
          sfpi_pkg::KD_OPC: begin
            opc_q    <= rx_byte_q;
            cls_q    <= sfpi_pkg::op_class(rx_byte_q, QUAD_LANES_ENABLE);
            abytes_q <= '0;
            if (sfpi_pkg::op_class(rx_byte_q, QUAD_LANES_ENABLE)
                == sfpi_pkg::CL_CHIP) begin
              CMD_ADDR   <= '0;
              ERASE_UNIT <= sfpi_pkg::EU_CHIP;
              if (BUSY || bp != 3'h0) begin
                CMD_REJECTED <= 1'b1;
              end else begin
                ERASE_VALID <= 1'b1;
              end
            end
          end
          sfpi_pkg::KD_ADDR: begin
            addr_q   <= {addr_q[7:0], rx_byte_q};
            abytes_q <= abytes_q + 2'h1;
            if (abytes_q == 2'h2) begin
              case (cls_q)
                sfpi_pkg::CL_READ: begin
                  CMD_ADDR   <= full_addr;
                  READ_START <= 1'b1;
                end
                sfpi_pkg::CL_PROG: begin
                  base_q <= full_addr;
                  pcnt_q <= '0;
                end
                sfpi_pkg::CL_ERASE: begin
                  CMD_ADDR   <= era_addr;
                  ERASE_UNIT <= sfpi_pkg::op_unit(opc_q);
                  if (BUSY || prot_hit(era_addr, bp, TOP_BOTTOM_SELECT,
                                       SECTOR_GRANULARITY_SELECT)
                      || prot_hit(era_addr | unit_mask(
                                    sfpi_pkg::op_unit(opc_q)),
                                  bp, TOP_BOTTOM_SELECT,
                                  SECTOR_GRANULARITY_SELECT)) begin
                    CMD_REJECTED <= 1'b1;
                  end else begin
                    ERASE_VALID <= 1'b1;
                  end
                end
                default: begin
                  CMD_REJECTED <= 1'b0;
                end
              endcase
            end
          end
          default: begin
            if (cls_q == sfpi_pkg::CL_PROG) begin
              // Column wraps inside the page; bytes past a page dropped
              if (pcnt_q != 9'(sfpi_pkg::PAGE_BYTES)) begin
                pcnt_q   <= pcnt_q + 9'h001;
                CMD_ADDR <= prog_addr;
                if (BUSY || prot_hit(prog_addr, bp, TOP_BOTTOM_SELECT,
                                     SECTOR_GRANULARITY_SELECT)) begin
                  CMD_REJECTED <= 1'b1;
                end else begin
                  PROG_VALID <= 1'b1;
                  PROG_DATA  <= rx_byte_q;
                end
              end
            end else if (cls_q == sfpi_pkg::CL_WSTAT) begin
              if (BUSY || st_locked) begin
                CMD_REJECTED <= 1'b1;
              end else begin
                STATUS_WR_VALID <= 1'b1;
                STATUS_WR_DATA  <= rx_byte_q;
              end
            end
          end
        endcase
      end
    end
  end

  // ****************************************
  // Read data path
  // ****************************************
  // The link copies tx_word_q a full serial clock after it was loaded
  assign tx_in_if.valid  = TX_VALID;
  assign tx_in_if.data   = TX_DATA;
  assign TX_READY        = tx_in_if.ready;
  assign fill            = tx_out_if.valid && !cs_s2_q
                           && (!tx_valid_q || tx_ev);
  assign tx_out_if.ready = fill && CE;

  sfpi_buf2 #(
    .W     (8),
    .DEPTH (2)
  ) u_txbuf (
    .clk   (CLK_SYS),
    .rst_n (NRST),
    .ce    (CE),
    .wr    (tx_in_if.snk),
    .rd    (tx_out_if.src)
  );

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      tx_word_q   <= '0;
      tx_valid_q  <= 1'b0;
      TX_UNDERRUN <= 1'b0;
    end else if (CE) begin
      TX_UNDERRUN <= tx_ev && !tx_valid_q && frame_ok_q;
      if (fill) begin
        tx_word_q  <= tx_out_if.data;
        tx_valid_q <= 1'b1;
      end else if (tx_ev || cs_s2_q) begin
        tx_valid_q <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// File: sfpi_host.sv
`default_nettype none
module sfpi_host (
  // Pins
  output logic            cs_n,
  output logic            sck,
  output logic      [3:0] io,
  input  wire logic       wp_n,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Host controller, clock mode 0: clock rests low outside frames
  // ****
  logic [3:0] drv = 4'h5;
  initial cs_n = 1'b1;
  initial sck = 1'b0;
  // No pull-up on the guard pin, so it is driven at all times
  always_comb begin
    io = (io_oe & io_out) | (~io_oe & {drv[3], wp_n, drv[1:0]});
  end
  task sel;
    #3 cs_n = 1'b0;
    #80;
  endtask
  task desel;
    #80 cs_n = 1'b1;
    drv = ~drv;
    #200;
  endtask
  task send(input logic [7:0] b);
    for (int k = 7; k >= 0; k--) begin
      drv[0] = b[k];
      #80 sck = 1'b1;
      #80 sck = 1'b0;
    end
    drv[0] = ~drv[0];
  endtask
  task adr(input logic [23:0] v);
    send(v[23:16]);
    send(v[15:8]);
    send(v[7:0]);
  endtask
  // Sample on rising edges; the device moved the lanes on the fall before
  task recv(input int n, output logic [7:0] r);
    r = 8'h00;
    for (int k = 0; k < 8 / n; k++) begin
      #80 sck = 1'b1;
      r = (n == 1) ? {r[6:0], io[1]} : (n == 2) ? {r[5:0], io[1:0]}
        : {r[3:0], io};
      #80 sck = 1'b0;
    end
  endtask
endmodule
`default_nettype wire

// File: sfpi_top_sva.sv
`default_nettype none
module sfpi_top_sva (
  // Clock and reset
  input wire logic       CLK_SYS,
  input wire logic       NRST,
  input wire logic       CE,
  // Pins and levels
  input wire logic       CS_N,
  input wire logic [3:0] IO_OE,
  input wire logic       BUSY,
  input wire logic       QUAD_LANES_ENABLE,
  input wire logic [1:0] STATUS_LOCK_BITS,
  // Watched outputs
  input wire logic       STANDBY,
  input wire logic       ACTIVE,
  input wire logic       READ_START,
  input wire logic       ERASE_VALID,
  input wire logic       STATUS_WR_VALID,
  input wire logic       POWERUP_EDGE_SEEN,
  input wire logic       HW_GUARD_ACTIVE
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!NRST);
  // Eight cycles leave room for the select synchronisers to settle
  sequence s_idle;
    (CS_N && !BUSY && CE) [*8];
  endsequence
  sequence s_sel;
    (!CS_N && CE && POWERUP_EDGE_SEEN) [*8];
  endsequence
  a_deselect_release: assert property (CS_N |-> IO_OE == 4'h0)
    else $error("lanes driven while deselected");
  a_standby_idle: assert property (s_idle |=> STANDBY)
    else $error("no standby while idle");
  a_busy_standby: assert property ((BUSY && CE) [*6] |=> !STANDBY)
    else $error("standby while busy");
  a_active_sel: assert property (s_sel |=> ACTIVE && !STANDBY)
    else $error("not active while selected");
  a_edge_first: assert property ((READ_START || ERASE_VALID
    || STATUS_WR_VALID) |-> POWERUP_EDGE_SEEN)
    else $error("command before first select edge");
  a_start_pulse: assert property (READ_START |=> !READ_START)
    else $error("read start longer than one cycle");
  a_lane_shape: assert property (IO_OE inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("bad lane enable pattern");
  a_lock_status: assert property (STATUS_WR_VALID |-> !STATUS_LOCK_BITS[1])
    else $error("status written while locked");
  a_quad_guard: assert property (QUAD_LANES_ENABLE |-> !HW_GUARD_ACTIVE)
    else $error("guard active with quad lanes");
endmodule
`default_nettype wire

// File: testbench.sv
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // Hookup
  // ****
  logic CLK_SYS, NRST, CE, CS_N, SCK, QUAD_LANES_ENABLE, BUSY, TX_VALID;
  logic SECTOR_GRANULARITY_SELECT, TOP_BOTTOM_SELECT, BLOCK_PROTECT_LEVEL_2;
  logic BLOCK_PROTECT_LEVEL_1, BLOCK_PROTECT_LEVEL_0, TX_READY, READ_START;
  logic ERASE_VALID, PROG_VALID, STATUS_WR_VALID, CMD_REJECTED, TX_UNDERRUN;
  logic STANDBY, ACTIVE, POWERUP_EDGE_SEEN, HW_GUARD_ACTIVE, wp_n;
  logic [1:0]  STATUS_LOCK_BITS, ERASE_UNIT;
  logic [3:0]  IO_IN, IO_OUT, IO_OE;
  logic [7:0]  TX_DATA, PROG_DATA, STATUS_WR_DATA, r;
  logic [7:0]  d [2];
  logic [23:0] CMD_ADDR, a;
  logic [31:0] seed;
  int err_total, n_checks, n_rs, n_er, n_rej, n_sw;
  logic [7:0] rops [3] = '{sfpi_pkg::OPC_READ, sfpi_pkg::OPC_DUAL_READ,
    sfpi_pkg::OPC_QUAD_READ};
  logic [7:0] eops [4] = '{sfpi_pkg::OPC_ERASE_4K, sfpi_pkg::OPC_ERASE_32K,
    sfpi_pkg::OPC_ERASE_64K, sfpi_pkg::OPC_CHIP_ERA};
  sfpi_top i_dut (.*);
  sfpi_host i_host (.cs_n(CS_N), .sck(SCK), .io(IO_IN), .wp_n(wp_n),
    .io_out(IO_OUT), .io_oe(IO_OE));
  initial begin
    CLK_SYS = 1'b0;
    forever #4 CLK_SYS = ~CLK_SYS;
  end
  always @(posedge CLK_SYS) begin
    n_rs += (READ_START === 1'b1);
    n_er += (ERASE_VALID === 1'b1);
    n_rej += (CMD_REJECTED === 1'b1);
    n_sw += (STATUS_WR_VALID === 1'b1);
  end
  task nx;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
  endtask
  function automatic logic [3:0] oe_of(input int n);
    return (n == 1) ? 4'h2 : (n == 2) ? 4'h3 : 4'hf;
  endfunction
  task chk(input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      err_total++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task end_of_test;
    $display("checks %0d errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task push(input logic [7:0] v);
    int w;
    w = 0;
    @(negedge CLK_SYS);
    TX_DATA = v;
    TX_VALID = 1'b1;
    while (TX_READY !== 1'b1 && w < 40) begin
      @(negedge CLK_SYS);
      w++;
    end
    if (w == 40) begin
      err_total++;
      end_of_test();
    end
    @(negedge CLK_SYS);
    TX_VALID = 1'b0;
  endtask
  task frame(input logic [7:0] op, input logic [23:0] ad, input int nb);
    i_host.sel();
    i_host.send(op);
    if (nb > 0) i_host.adr(ad);
    if (nb > 1) i_host.send(seed[7:0]);
    if (nb > 2) i_host.send(seed[15:8]);
  endtask
  initial begin
    #500000;
    err_total++;
    end_of_test();
  end
  initial begin
    {NRST, CE, QUAD_LANES_ENABLE, BUSY, TX_VALID, wp_n} = 6'b010001;
    {SECTOR_GRANULARITY_SELECT, TOP_BOTTOM_SELECT, BLOCK_PROTECT_LEVEL_2,
      BLOCK_PROTECT_LEVEL_1, BLOCK_PROTECT_LEVEL_0} = 5'h00;
    STATUS_LOCK_BITS = 2'h0;
    TX_DATA = 8'h00;
    seed = 32'h4884c303;
    // Select held across reset release: that frame must be dropped
    i_host.cs_n = 1'b0;
    repeat (8) @(negedge CLK_SYS);
    NRST = 1'b1;
    i_host.send(sfpi_pkg::OPC_READ);
    i_host.adr(24'h000100);
    i_host.desel();
    chk(n_rs, 0);
    chk(POWERUP_EDGE_SEEN, 1'b0);
    repeat (4) begin
      nx();
      i_host.drv = seed[3:0];
      #150;
    end
    chk(STANDBY, 1'b1);
    BUSY = 1'b1;
    repeat (10) @(negedge CLK_SYS);
    chk(STANDBY, 1'b0);
    BUSY = 1'b0;
    QUAD_LANES_ENABLE = 1'b1;
    for (int k = 0; k < 3; k++) begin
      nx();
      a = seed[31:8];
      d = '{seed[7:0], seed[15:8]};
      push(d[0]);
      push(d[1]);
      chk(TX_READY, 1'b0);
      frame(rops[k], a, (k > 0) ? 2 : 1);
      for (int j = 0; j < 2; j++) begin
        i_host.recv(1 << k, r);
        chk(r, d[j]);
      end
      chk(IO_OE, oe_of(1 << k));
      chk(ACTIVE, 1'b1);
      i_host.desel();
      chk(CMD_ADDR, a);
      chk(n_rs, k + 1);
    end
    for (int k = 0; k < 4; k++) begin
      nx();
      frame(eops[k], seed[23:0], (k < 3) ? 1 : 0);
      i_host.desel();
      chk(ERASE_UNIT, k);
      chk(n_er, k + 1);
    end
    {BLOCK_PROTECT_LEVEL_2, BLOCK_PROTECT_LEVEL_1, BLOCK_PROTECT_LEVEL_0} = 3'h7;
    frame(sfpi_pkg::OPC_ERASE_4K, seed[23:0], 1);
    i_host.desel();
    chk(n_rej, 1);
    chk(n_er, 4);
    {BLOCK_PROTECT_LEVEL_2, BLOCK_PROTECT_LEVEL_1, BLOCK_PROTECT_LEVEL_0} = 3'h0;
    for (int k = 0; k < 2; k++) begin
      STATUS_LOCK_BITS = k ? 2'h0 : 2'h2;
      nx();
      i_host.sel();
      i_host.send(sfpi_pkg::OPC_WR_STATUS);
      i_host.send(seed[7:0]);
      i_host.desel();
      chk(n_sw, k);
      chk(n_rej, 2);
    end
    chk(STATUS_WR_DATA, seed[7:0]);
    a = {seed[23:8], 8'hff};
    frame(sfpi_pkg::OPC_PAGE_PROG, a, 3);
    i_host.desel();
    chk(PROG_DATA, seed[15:8]);
    chk(CMD_ADDR, {a[23:8], 8'h00});
    wp_n = 1'b0;
    for (int k = 0; k < 2; k++) begin
      QUAD_LANES_ENABLE = k[0];
      repeat (6) @(negedge CLK_SYS);
      chk(HW_GUARD_ACTIVE, !k[0]);
    end
    end_of_test();
  end
endmodule
bind sfpi_top sfpi_top_sva i_sva (.*);
`default_nettype wire
